// ---- src/mabi_bus_interface.sv ----
// Host-side control of the multiplexed 8-bit converter.
// What this block does
// R1 - Configuration bits share low data lines; taken only while read strobe high.
// R2 - Conversion starts only on select low with a write or read strobe pulse.
// R3 - Done flag stays low while a finished result is unread and no write strobe falls.
// R4 - Write strobe falling edge raises done flag and readies new conversion.
// R5 - Write rising edge with read high latches configuration, starts conversion.
// R6 - Read low across whole write keeps configuration, drives prior result.
// R7 - Completion latches result, lowers done flag; conversion within 40 us.
// R8 - Select and read low raise done flag and drive the result.
// R9 - Host reads no sooner than 600 ns after done flag falls.
// R10 - Converts positive minus negative; zero code when positive is lower.
// R11 - Bit 3 low pairs; bit 3 high single-ended; bits 3,4 high pseudo.
// R12 - Differential pairs one-two, three-four; either may be positive.
// R13 - Four-channel single-ended: channels one to four against ground.
// R14 - Four-channel pseudo: channels one to three against channel four.
// R15 - 256 codes across reference span; one step is reference over 256.
// R16 - Select-and-read also restarts conversion with unchanged configuration.
// R17 - Host may write immediately after a restarting read.
// R18 - Data lines released whenever select or read strobe is high.
// R19 - Eight-channel: pseudo uses one to seven, single-ended one to eight.
`timescale 1ns/1ps
module mabi_bus_interface #(
  parameter int CHANNELS = 4 // Channel count, 4 or 8.
) (
  input wire logic clk_i, // System clock, 100 MHz.
  input wire logic sys_rst_i, // Synchronous reset, active high.
  input wire mabi_pkg::mabi_strobe_type strobe_i, // Host select, write, read strobes.
  input wire logic [7:0] parallel_bus_lines_i, // Data lines as seen on the bus.
  output logic [7:0] parallel_bus_lines_o, // Data driven onto the bus.
  output logic parallel_bus_lines_oe_n_o, // Low while driving the data lines.
  output logic result_ready_n_o, // Done flag, low when result unread.
  input wire logic comp_i, // Comparator from analog front end.
  output logic [7:0] trial_code_o, // Trial code for the reference ladder.
  output mabi_pkg::mabi_select_type input_selector_o, // Selected + and - inputs.
  output logic [4:0] channel_cfg_bits_o, // Latched configuration.
  output logic busy_o // Conversion running.
);
  import mabi_pkg::*;

  logic wr_low;
  logic rd_low;
  logic wr_low_q;
  logic rd_low_q;
  logic wr_fall;
  logic wr_rise;
  logic rd_fall;
  logic rd_held;
  logic start;
  logic sar_done;
  logic [7:0] sar_code;
  logic [7:0] out_latch;
  logic [4:0] cfg_latch;
  mabi_select_type next_select;

  // Strobes qualified by select; a strobe without select is ignored.
  assign wr_low = !strobe_i.cs_n && !strobe_i.wr_n; // R2
  assign rd_low = !strobe_i.cs_n && !strobe_i.rd_n;

  // Strobe history for edge detection.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_low_q <= 1'b0;
      rd_low_q <= 1'b0;
    end else begin
      wr_low_q <= wr_low;
      rd_low_q <= rd_low;
    end
  end

  assign wr_fall = wr_low && !wr_low_q;
  assign wr_rise = !wr_low && wr_low_q;
  assign rd_fall = rd_low && !rd_low_q;

  // Tracks whether read stayed low through the whole write low period.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_held <= 1'b0;
    end else if (wr_fall) begin
      rd_held <= !strobe_i.rd_n;
    end else if (wr_low && strobe_i.rd_n) begin
      rd_held <= 1'b0; // R6
    end
  end

  // A write release or a read starts a new conversion.
  assign start = wr_rise || rd_fall; // R2 R5 R16

  // Configuration latch; data lines count as configuration only with read high.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_latch <= CFG_RESET;
    end else if (wr_rise && strobe_i.rd_n && !rd_held) begin
      cfg_latch <= parallel_bus_lines_i[CFG_BITS-1:0]; // R1 R5
    end
  end
  assign channel_cfg_bits_o = cfg_latch;

  // Input decode. Codes for channels beyond the part fall back to ground.
  always_comb begin
    next_select.mode = MABI_MODE_DIFF;
    next_select.pos_sel = SEL_GROUND;
    next_select.neg_sel = SEL_GROUND;
    if (!cfg_latch[CFG_SE_BIT]) begin
      // Adjacent pairs; polarity bit picks the positive member.
      next_select.mode = MABI_MODE_DIFF; // R11 R12
      next_select.pos_sel = {cfg_latch[2:1], 1'b0} + 4'h1 + {3'h0, cfg_latch[CFG_POL_BIT]};
      next_select.neg_sel = {cfg_latch[2:1], 1'b0} + 4'h2 - {3'h0, cfg_latch[CFG_POL_BIT]};
    end else if (!cfg_latch[CFG_PSEUDO_BIT]) begin
      next_select.mode = MABI_MODE_SINGLE; // R11 R13 R19
      next_select.pos_sel = {1'b0, cfg_latch[2:0]} + 4'h1;
      next_select.neg_sel = SEL_GROUND;
    end else begin
      // Last channel is the pseudo-ground and cannot be a positive input.
      next_select.mode = MABI_MODE_PSEUDO; // R11 R14 R19
      next_select.pos_sel = {1'b0, cfg_latch[2:0]} + 4'h1;
      next_select.neg_sel = 4'(CHANNELS);
      if (next_select.pos_sel >= 4'(CHANNELS)) begin
        next_select.pos_sel = SEL_GROUND;
      end
    end
    if (next_select.pos_sel > 4'(CHANNELS) || next_select.neg_sel > 4'(CHANNELS)) begin
      next_select.pos_sel = SEL_GROUND;
      next_select.neg_sel = SEL_GROUND;
    end
  end

  // Selection is registered so the analog side sees steady codes.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      input_selector_o <= '0;
    end else begin
      input_selector_o <= next_select; // R10
    end
  end

  // The approximation engine; 256 codes over the reference span.
  mabi_sar_core u_sar (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(start),
    .abort_i(wr_fall),
    .comp_i(comp_i),
    .trial_o(trial_code_o), // R15
    .busy_o(busy_o),
    .done_o(sar_done),
    .code_o(sar_code)
  );

  // Output latch takes the finished code.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      out_latch <= RESULT_RESET;
    end else if (sar_done) begin
      out_latch <= sar_code; // R7
    end
  end

  // Done flag: completion sets it low and wins over a same-cycle clear.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      result_ready_n_o <= 1'b1;
    end else if (sar_done) begin
      result_ready_n_o <= 1'b0; // R3 R7
    end else if (wr_fall || rd_fall) begin
      result_ready_n_o <= 1'b1; // R4 R8
    end
  end

  // Read drives the result; the bus is released otherwise to avoid contention.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      parallel_bus_lines_o <= 8'h00;
      parallel_bus_lines_oe_n_o <= 1'b1;
    end else if (rd_low) begin
      parallel_bus_lines_o <= out_latch; // R6 R8
      parallel_bus_lines_oe_n_o <= 1'b0;
    end else begin
      parallel_bus_lines_o <= 8'h00;
      parallel_bus_lines_oe_n_o <= 1'b1; // R18
    end
  end

endmodule : mabi_bus_interface

// ---- inc/mabi_pkg.sv ----
// Package for the converter bus interface: constants, modes and carrier types.
package mabi_pkg;

  // Clock rate and conversion timing.
  localparam int CLK_MHZ = 100;
  localparam int CONV_TIME_US = 40;
  // Longest time expressed in whole clock cycles.
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
  // Successive approximation steps, one per result bit.
  localparam int RESULT_BITS = 8;
  localparam int STEP_CYCLES = CONV_CYCLES / RESULT_BITS;
  localparam int CFG_BITS = 5;
  localparam int CHAN_MAX = 8;

  // Field positions in the configuration latch.
  localparam int CFG_POL_BIT = 0;
  localparam int CFG_SE_BIT = 3;
  localparam int CFG_PSEUDO_BIT = 4;

  // Reset values.
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // Channel selector codes: 0 is analog ground, 1 to 8 are channels.
  localparam logic [3:0] SEL_GROUND = 4'h0;

  typedef enum logic [1:0] {
    MABI_MODE_DIFF = 2'b00,
    MABI_MODE_SINGLE = 2'b01,
    MABI_MODE_PSEUDO = 2'b11
  } mabi_mode_type;

  // Host strobe group, all active low.
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
  } mabi_strobe_type;

  // Decoded input selection.
  typedef struct packed {
    mabi_mode_type mode;
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
  } mabi_select_type;

endpackage : mabi_pkg

// ---- src/mabi_sar_core.sv ----
// Successive-approximation sequencer paced by an internal step enable.
`timescale 1ns/1ps
module mabi_sar_core (
  input wire logic clk_i, // System clock.
  input wire logic sys_rst_i, // Synchronous reset, active high.
  input wire logic start_i, // One-cycle pulse that starts a conversion.
  input wire logic abort_i, // One-cycle pulse that cancels a conversion.
  input wire logic comp_i, // Comparator: trial level below difference.
  output logic [7:0] trial_o, // Present trial code for the DAC.
  output logic busy_o, // Conversion in progress.
  output logic done_o, // One-cycle pulse at completion.
  output logic [7:0] code_o // Finished code, valid with done_o.
);
  import mabi_pkg::*;

  logic [$clog2(STEP_CYCLES)-1:0] step_cnt;
  logic [2:0] bit_idx;
  logic step_en;

  // Divider: one enable per approximation step.
  assign step_en = busy_o && (step_cnt == ($clog2(STEP_CYCLES))'(STEP_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || start_i || !busy_o || step_en) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + 1'b1;
    end
  end

  // Bit-by-bit approximation; a below-negative input leaves every bit cleared.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || abort_i) begin
      busy_o <= 1'b0;
      bit_idx <= 3'h0;
      trial_o <= 8'h00;
      done_o <= 1'b0;
      code_o <= 8'h00;
    end else if (start_i) begin
      busy_o <= 1'b1;
      bit_idx <= 3'h7;
      trial_o <= 8'h80;
      done_o <= 1'b0;
    end else if (step_en) begin
      logic [7:0] kept;
      kept = comp_i ? trial_o : (trial_o & ~(8'h01 << bit_idx)); // R10
      if (bit_idx == 3'h0) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
        code_o <= kept;
        trial_o <= kept;
      end else begin
        trial_o <= kept | (8'h01 << (bit_idx - 3'h1));
        bit_idx <= bit_idx - 3'h1;
      end
    end else begin
      done_o <= 1'b0;
    end
  end

endmodule : mabi_sar_core

// ---- tb/mabi_host_model.sv ----
// Host bus model: strobes from a command code, config drive with hold.
`timescale 1ns/1ps
module mabi_host_model (
  input wire logic clk_i, // Clock.
  input wire logic [1:0] cmd_i, // Bit 0 write, bit 1 read.
  input wire logic [4:0] cfg_i, // Config to write.
  input wire logic [7:0] dev_i, // Device data.
  input wire logic dev_oe_n_i, // Device drives when low.
  output mabi_pkg::mabi_strobe_type strobe_o, // Strobes.
  output logic [7:0] bus_o // Line levels.
);
  import mabi_pkg::*;
  logic hold;
  logic [7:0] last;
  // Select falls with either strobe, the only way to start a conversion.
  assign strobe_o = '{cmd_i == 2'h0, !cmd_i[0], !cmd_i[1]};
  // Config is held a cycle past the write; an undriven line flips, never keeps a stale value.
  assign bus_o = !dev_oe_n_i ? dev_i : (cmd_i == 2'h1 || hold) ? {3'h0, cfg_i} : ~last;
  // Remember the write and the line levels.
  always_ff @(posedge clk_i) begin
    hold <= cmd_i == 2'h1;
    last <= bus_o;
  end
endmodule : mabi_host_model

// ---- tb/mabi_bus_interface_chk.sv ----
// Port assertions for the converter bus interface.
`timescale 1ns/1ps
module mabi_bus_interface_chk (
  input wire logic clk_i, // Clock.
  input wire logic sys_rst_i, // Reset.
  input wire mabi_pkg::mabi_strobe_type strobe_i, // Strobes.
  input wire logic [7:0] parallel_bus_lines_i, // Lines.
  input wire logic parallel_bus_lines_oe_n_o, // Drive.
  input wire logic result_ready_n_o, // Done flag.
  input wire logic [4:0] channel_cfg_bits_o, // Latch.
  input wire logic busy_o // Busy.
);
  import mabi_pkg::*;
  logic wr;
  logic rd;
  logic [12:0] cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Select qualifies both strobes.
  assign wr = !strobe_i.cs_n && !strobe_i.wr_n;
  assign rd = !strobe_i.cs_n && !strobe_i.rd_n;
  // Busy cycles since the last start; too long a run means a stuck sequencer.
  always_ff @(posedge clk_i) begin
    cnt <= (!busy_o || $fell(wr) || $rose(rd)) ? 13'h0 : cnt + 13'h1;
  end
  property p_rel; !rd && !$past(rd) |-> parallel_bus_lines_oe_n_o; endproperty
  a_rel: assert property (p_rel) else $error("lines driven");
  property p_rd; $rose(rd) |=> !parallel_bus_lines_oe_n_o && result_ready_n_o; endproperty
  a_rd: assert property (p_rd) else $error("read response");
  property p_wrf; $rose(wr) |=> result_ready_n_o; endproperty
  a_wrf: assert property (p_wrf) else $error("flag not raised");
  property p_lat;
    $fell(wr) && strobe_i.rd_n |=> channel_cfg_bits_o == $past(parallel_bus_lines_i[4:0]);
  endproperty
  a_lat: assert property (p_lat) else $error("config latch");
  property p_keep; $fell(wr) && !strobe_i.rd_n |=> $stable(channel_cfg_bits_o); endproperty
  a_keep: assert property (p_keep) else $error("config changed");
  property p_go; ($fell(wr) && strobe_i.rd_n) || $rose(rd) |=> busy_o; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_time; busy_o |-> cnt < 13'd4010; endproperty
  a_time: assert property (p_time) else $error("conversion too long");
  property p_hold;
    !result_ready_n_o && !$rose(rd) && !$rose(wr) |=> !result_ready_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
endmodule : mabi_bus_interface_chk
bind mabi_bus_interface mabi_bus_interface_chk u_chk (.clk_i, .sys_rst_i, .strobe_i,
  .parallel_bus_lines_i, .parallel_bus_lines_oe_n_o, .result_ready_n_o, .channel_cfg_bits_o,
  .busy_o);

// ---- tb/mabi_bus_interface_tb_top.sv ----
// Self-checking bench for the converter bus interface.
`timescale 1ns/1ps
module mabi_bus_interface_tb_top;
  import mabi_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic comp_i;
  logic busy_o;
  logic parallel_bus_lines_oe_n_o;
  logic result_ready_n_o;
  logic [1:0] cmd = 2'h0;
  logic [4:0] cfg = 5'h00;
  logic [4:0] channel_cfg_bits_o;
  logic [7:0] parallel_bus_lines_i;
  logic [7:0] parallel_bus_lines_o;
  logic [7:0] trial_code_o;
  logic [7:0] vals [9] = '{0: 8'h00, 1: 8'h90, 2: 8'h30, 3: 8'h55, 4: 8'h20, default: 8'h00};
  logic [4:0] codes [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0a, 5'h0b,
    5'h18, 5'h19, 5'h1a};
  mabi_strobe_type strobe_i;
  mabi_select_type input_selector_o;
  int error_cnt = 0;
  int total_checks = 0;
  // Clamped span between two inputs; a reversed pair reads as zero.
  function automatic logic [7:0] span(input logic [3:0] p, input logic [3:0] n);
    return vals[p] > vals[n] ? vals[p] - vals[n] : 8'h00;
  endfunction : span
  // Code expected for a configuration of the four-channel part.
  function automatic logic [7:0] expect_code(input logic [4:0] c);
    logic [3:0] b;
    b = {1'b0, c[2:1], 1'b0} + 4'h1;
    if (!c[3]) return span(b + {3'h0, c[0]}, b + {3'h0, !c[0]});
    return span({1'b0, c[2:0]} + 4'h1, c[4] ? 4'h4 : SEL_GROUND);
  endfunction : expect_code
  // Clock, and a comparator that keeps a trial bit fitting the selected span.
  always #5 clk_i = ~clk_i;
  assign comp_i = trial_code_o <= span(input_selector_o.pos_sel, input_selector_o.neg_sel);
  mabi_bus_interface #(.CHANNELS(4)) DUT (.clk_i, .sys_rst_i, .strobe_i, .parallel_bus_lines_i,
    .parallel_bus_lines_o, .parallel_bus_lines_oe_n_o, .result_ready_n_o, .comp_i,
    .trial_code_o, .input_selector_o, .channel_cfg_bits_o, .busy_o);
  mabi_host_model host (.clk_i, .cmd_i(cmd), .cfg_i(cfg), .dev_i(parallel_bus_lines_o),
    .dev_oe_n_i(parallel_bus_lines_oe_n_o), .strobe_o(strobe_i), .bus_o(parallel_bus_lines_i));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Hold a command for n edges, then return at mid-cycle where outputs are settled.
  task automatic drive(input logic [1:0] c, input logic [4:0] d, input int n);
    @(posedge clk_i);
    cmd <= c;
    cfg <= d;
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : drive
  // Wait for the flag, stay clear of it for 600 ns, then read the result.
  task automatic collect(input logic [7:0] exp);
    repeat (4100) if (result_ready_n_o !== 1'b0) @(negedge clk_i);
    repeat (60) @(negedge clk_i);
    check("done flag", 8'h00, {7'h00, result_ready_n_o});
    drive(2'h2, cfg, 2);
    check("read data", exp, parallel_bus_lines_o);
    check("flag and drive", 8'h02, {6'h00, result_ready_n_o, parallel_bus_lines_oe_n_o});
    drive(2'h0, cfg, 3);
  endtask : collect
  task automatic convert(input logic [4:0] d);
    drive(2'h1, d, 2);
    check("flag after write", 8'h01, {7'h00, result_ready_n_o});
    drive(2'h0, d, 1);
    check("config latch", {3'h0, d}, {3'h0, channel_cfg_bits_o});
    collect(expect_code(d));
  endtask : convert
  task automatic t_modes;
    foreach (codes[i]) convert(codes[i]);
    $display("modes test done");
  endtask : t_modes
  // A read held low across a whole write keeps the latch and restarts conversion.
  task automatic t_keep;
    drive(2'h2, 5'h05, 1);
    drive(2'h3, 5'h05, 2);
    check("prior result", expect_code(5'h1a), parallel_bus_lines_o);
    drive(2'h2, 5'h05, 1);
    drive(2'h0, 5'h05, 2);
    check("config kept", 8'h1a, {3'h0, channel_cfg_bits_o});
    collect(expect_code(5'h1a));
    $display("keep test done");
  endtask : t_keep
  // Let the restarted conversion finish unread, so the write must visibly raise the flag.
  task automatic t_b2b;
    repeat (4100) if (result_ready_n_o !== 1'b0) @(negedge clk_i);
    check("unread flag", 8'h00, {7'h00, result_ready_n_o});
    convert(5'h09);
    drive(2'h2, 5'h00, 2);
    convert(5'h08);
    $display("back-to-back test done");
  endtask : t_b2b
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // Ten cycles of reset, then the scenarios; fifteen conversions take about 61k cycles.
  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_modes;
    t_keep;
    t_b2b;
    tally_and_finish;
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish;
  end
endmodule : mabi_bus_interface_tb_top
